// ---- lids_chk.sv ----
// Purpose: port checks for lids_top
// Assumes: one clock, async active-low reset
// Notes: bound from tb
module lids_chk (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic tx_shaping_select_o,
  input wire logic far_loop_select_o,
  input wire logic near_loop_select_o,
  input wire logic rx_signal_lost_i,
  input wire logic loss_of_signal_o,
  input wire logic los_change_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_drv_wr;
    reg_wr_i && reg_addr_i == 8'h80;
  endsequence
  sequence s_los_steady;
    $stable(rx_signal_lost_i) [*2];
  endsequence
  chk_ack_strobe: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o) else $error("no ack");
  chk_shape_pin: assert property (s_drv_wr |=> tx_shaping_select_o == $past(reg_wdata_i[2])) else $error("shape");
  chk_far_pin: assert property (s_drv_wr |=> far_loop_select_o == $past(reg_wdata_i[1])) else $error("far");
  chk_near_pin: assert property (s_drv_wr |=> near_loop_select_o == $past(reg_wdata_i[0])) else $error("near");
  chk_scan_upper: assert property (reg_rd_i && reg_addr_i == 8'h81 |=> reg_rdata_o[7:3] == 5'h00) else $error("upper");
  chk_los_level: assert property (s_los_steady |=> loss_of_signal_o == $past(rx_signal_lost_i)) else $error("los");
  chk_los_event: assert property ($changed(loss_of_signal_o) |=> los_change_o) else $error("no event");
  chk_los_quiet: assert property ($stable(loss_of_signal_o) |=> !los_change_o) else $error("stray event");
endmodule : lids_chk

// ---- lids_liu_model.sv ----
// Purpose: companion line unit status pins
// Assumes: cond_i gives line conditions
// Notes: levels only, no line timing
module lids_liu_model (
  input wire logic [2:0] cond_i,
  output logic driver_activity_monitor_o,
  output logic rx_lock_lost_o,
  output logic rx_signal_lost_o
);
  // no bipolar activity seen drives monitor high
  assign driver_activity_monitor_o = cond_i[2];
  assign rx_lock_lost_o = cond_i[1];
  assign rx_signal_lost_o = cond_i[0];
endmodule : lids_liu_model

// ---- lids_pkg.sv ----
// Purpose: shared constants for the line interface drive and scan block
// Assumes: 8-bit processor register port, byte offsets as printed
// Notes: drive register bit 6 is unused and reads zero
package lids_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  localparam logic [7:0] DRIVE_OFFSET = 8'h80;
  localparam logic [7:0] SCAN_OFFSET = 8'h81;

  // drive register field positions
  localparam int unsigned NEAR_LOOP_BIT = 0;
  localparam int unsigned FAR_LOOP_BIT = 1;
  localparam int unsigned TX_SHAPING_BIT = 2;
  localparam int unsigned ENCODER_DIS_BIT = 3;
  localparam int unsigned TX_ALL_ONES_BIT = 4;
  localparam int unsigned RX_EQUALIZER_BIT = 5;
  localparam int unsigned INT_REMOTE_LOOP_BIT = 7;

  localparam logic [7:0] DRIVE_RESET = 8'h08;
  localparam logic [7:0] DRIVE_WRITE_MASK = 8'hBF;

  // scan register field positions
  localparam int unsigned RX_SIGNAL_LOST_BIT = 0;
  localparam int unsigned RX_LOCK_LOST_BIT = 1;
  localparam int unsigned DRIVER_MONITOR_BIT = 2;
  localparam int unsigned SCAN_W = 3;
  localparam logic [2:0] SCAN_RESET = 3'h3;

  localparam logic [7:0] UNMAPPED_READ = 8'h00;

endpackage : lids_pkg

// ---- lids_sync.sv ----
// Purpose: two-stage synchroniser for the monitor input pins
// Assumes: inputs are quasi-static levels from the companion chip
// Notes: first stage feeds only the second stage
module lids_sync #(
  parameter int unsigned WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta_reg;
      logic stable_reg;
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          meta_reg <= RESET_VAL[gi];
          stable_reg <= RESET_VAL[gi];
        end else begin
          meta_reg <= async_i[gi];
          stable_reg <= meta_reg;
        end
      end
      assign sync_o[gi] = stable_reg;
    end
  endgenerate

endmodule : lids_sync

// ---- lids_tb.sv ----
// Purpose: random and corner test of lids_top
// Assumes: 25 MHz clock, one-cycle ack
// Notes: inputs change 2 ns after the edge
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [2:0] cond = 3'h0;
  logic [7:0] reg_rdata_o, rd_val, d;
  logic reg_ack_o, tx_shaping_select_o, far_loop_select_o, near_loop_select_o, encoder_disable_o;
  logic tx_all_ones_select_o, rx_equalizer_select_o, internal_remote_loop_o, loss_of_signal_o, los_change_o;
  logic driver_activity_monitor_i, rx_lock_lost_i, rx_signal_lost_i;
  int n_errors = 0;
  int checks_done = 0;
  wire logic [7:0] pins = {internal_remote_loop_o, 1'b0, rx_equalizer_select_o, tx_all_ones_select_o,
    encoder_disable_o, tx_shaping_select_o, far_loop_select_o, near_loop_select_o};
  always #20 clock_i = ~clock_i;
  lids_top u_dut (.*);
  lids_liu_model u_liu (.cond_i(cond), .driver_activity_monitor_o(driver_activity_monitor_i),
    .rx_lock_lost_o(rx_lock_lost_i), .rx_signal_lost_o(rx_signal_lost_i));
  function automatic logic [7:0] drive_exp(input logic [7:0] v);
    return v & 8'hBF;
  endfunction : drive_exp
  function automatic logic [7:0] scan_exp(input logic [2:0] c);
    return {5'h00, c};
  endfunction : scan_exp
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    int i;
    reg_wr_i = w;
    reg_rd_i = !w;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(posedge clock_i);
    #2;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    for (i = 0; i < 4 && reg_ack_o !== 1'b1; i++) @(posedge clock_i) #2;
    if (i == 4) begin
      n_errors++;
      report_and_stop();
    end
    rd_val = reg_rdata_o;
    @(posedge clock_i) #2;
  endtask : acc
  initial begin
    void'($urandom(22));
    repeat (16) @(posedge clock_i);
    #2;
    reset_n_i = 1'b1;
    cmp8(pins, 8'h08);
    for (int k = 0; k < 12; k++) begin
      // corners first: every loop mode with bit 6 set, shaping high as for a long cable
      d = (k < 4) ? (8'hFC | 8'(k)) : 8'($urandom);
      acc(1'b1, 8'h80, d);
      cmp8(pins, drive_exp(d));
      acc(1'b1, 8'h81, ~d);
      cmp8(pins, drive_exp(d));
      acc(1'b0, 8'h80, 8'h00);
      cmp8(rd_val, drive_exp(d));
      cond = (k == 0) ? 3'h7 : 3'($urandom);
      repeat (3) @(posedge clock_i);
      #2;
      acc(1'b0, 8'h81, 8'h00);
      cmp8(rd_val, scan_exp(cond));
      cmp8({7'h00, loss_of_signal_o}, {7'h00, cond[0]});
      acc(1'b0, 8'h82 + 8'(k), 8'h00);
      cmp8(rd_val, 8'h00);
    end
    report_and_stop();
  end
endmodule : tb

bind lids_top lids_chk u_chk (.*);

// ---- lids_top.sv ----
// Purpose: drive pins and monitor scan for a companion line interface unit
// Assumes: single 25 MHz clock, 8-bit register port with one-cycle read latency
// Notes: drive pins come straight from the stored register bits
module lids_top (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  output logic tx_shaping_select_o,
  output logic far_loop_select_o,
  output logic near_loop_select_o,
  output logic encoder_disable_o,
  output logic tx_all_ones_select_o,
  output logic rx_equalizer_select_o,
  output logic internal_remote_loop_o,
  input wire logic driver_activity_monitor_i,
  input wire logic rx_lock_lost_i,
  input wire logic rx_signal_lost_i,
  output logic loss_of_signal_o,
  output logic los_change_o
);

  logic [7:0] drive_reg;
  logic [7:0] drive_next;
  logic [lids_pkg::SCAN_W-1:0] scan_raw;
  logic [lids_pkg::SCAN_W-1:0] scan_sync;
  logic los_prev_reg;
  logic los_change_reg;
  logic [7:0] rdata_reg;
  logic ack_reg;
  logic drive_wr;
  logic drive_hit;
  logic scan_hit;
  logic [7:0] read_value;

  assign drive_hit = (reg_addr_i == lids_pkg::DRIVE_OFFSET);
  assign scan_hit = (reg_addr_i == lids_pkg::SCAN_OFFSET);
  // scan hit never takes a write
  assign drive_wr = reg_wr_i && drive_hit;

  // unused bit 6 stays zero whatever is written
  always_comb begin
    drive_next = drive_reg;
    if (drive_wr) begin
      drive_next = reg_wdata_i & lids_pkg::DRIVE_WRITE_MASK;
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      drive_reg <= lids_pkg::DRIVE_RESET;
    end else begin
      drive_reg <= drive_next;
    end
  end

  // pins are the register bits themselves, so they switch on the write edge
  // and act as plain outputs when no line interface unit is fitted
  assign tx_shaping_select_o = drive_reg[lids_pkg::TX_SHAPING_BIT];
  assign far_loop_select_o = drive_reg[lids_pkg::FAR_LOOP_BIT];
  assign near_loop_select_o = drive_reg[lids_pkg::NEAR_LOOP_BIT];
  assign encoder_disable_o = drive_reg[lids_pkg::ENCODER_DIS_BIT];
  assign tx_all_ones_select_o = drive_reg[lids_pkg::TX_ALL_ONES_BIT];
  assign rx_equalizer_select_o = drive_reg[lids_pkg::RX_EQUALIZER_BIT];
  assign internal_remote_loop_o = drive_reg[lids_pkg::INT_REMOTE_LOOP_BIT];

  // monitor pins; partner timing of the activity flag is its own business
  assign scan_raw[lids_pkg::RX_SIGNAL_LOST_BIT] = rx_signal_lost_i;
  assign scan_raw[lids_pkg::RX_LOCK_LOST_BIT] = rx_lock_lost_i;
  assign scan_raw[lids_pkg::DRIVER_MONITOR_BIT] = driver_activity_monitor_i;

  lids_sync #(
    .WIDTH(lids_pkg::SCAN_W),
    .RESET_VAL(lids_pkg::SCAN_RESET)
  ) u_scan_sync (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .async_i(scan_raw),
    .sync_o(scan_sync)
  );

  // loss declared while the synchronised level is high
  assign loss_of_signal_o = scan_sync[lids_pkg::RX_SIGNAL_LOST_BIT];

  // change event on either edge; a synchronised level, so no glitch to chase
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      los_prev_reg <= lids_pkg::SCAN_RESET[lids_pkg::RX_SIGNAL_LOST_BIT];
      los_change_reg <= 1'b0;
    end else begin
      los_prev_reg <= scan_sync[lids_pkg::RX_SIGNAL_LOST_BIT];
      los_change_reg <= los_prev_reg ^ scan_sync[lids_pkg::RX_SIGNAL_LOST_BIT];
    end
  end
  assign los_change_o = los_change_reg;

  always_comb begin
    read_value = lids_pkg::UNMAPPED_READ;
    if (drive_hit) begin
      read_value = drive_reg;
    end else if (scan_hit) begin
      read_value = {5'h00, scan_sync};
    end
  end

  // read data registered: answer one cycle after the strobe
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= reg_rd_i | reg_wr_i;
      if (reg_rd_i) begin
        rdata_reg <= read_value;
      end
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign reg_ack_o = ack_reg;

endmodule : lids_top
